// ### common/pidrs_pkg.sv
// shared constants, types and helpers for the pid regulator supervisor
package pidrs_pkg;
    // timing: core clock, control period, ramp step unit
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int RAMP_UNIT_NS = 10000;
    localparam int RAMP_UNIT_CYC = RAMP_UNIT_NS / CLK_NS;
    // value scaling: 0.01 % per lsb, 10000 = maximum output frequency
    localparam logic signed [31:0] FULL_SCALE = 32'sh2710;
    localparam logic signed [31:0] VAL_MAX = 32'sh7fff;
    localparam logic signed [16:0] OFFSET_SCALE = 17'sh0000a;
    localparam int KP_FRAC = 8;
    localparam int KI_FRAC = 12;
    localparam int KD_FRAC = 8;
    localparam int GAIN_FRAC = 8;
    // reset values
    localparam logic signed [31:0] ACC_RST = 32'sh0;
    localparam logic [15:0] OUT_RST = 16'h0000;
    // contact input function codes
    localparam logic [7:0] CODE_DISABLE = 8'h13;
    localparam logic [7:0] CODE_INT_RESET = 8'h1e;
    localparam logic [7:0] CODE_INT_HOLD = 8'h1f;
    localparam logic [7:0] CODE_SOFT_START = 8'h22;
    localparam logic [7:0] CODE_INPUT_INV = 8'h23;
    // method and feedback-loss mode encodings
    localparam logic [2:0] METHOD_FIRST = 3'h1;
    localparam logic [2:0] METHOD_LAST = 3'h4;
    localparam logic [1:0] LOSS_ALARM = 2'h1;
    localparam logic [1:0] LOSS_FAULT = 2'h2;

    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_FAULT} pidrs_state_e;

    // methods 3 and 4 add the output to the reference
    function automatic logic is_comp(input logic [2:0] m);
        return (m == 3'h3) || (m == 3'h4);
    endfunction

    // methods 2 and 4 differentiate the feedback
    function automatic logic diff_fb(input logic [2:0] m);
        return (m == 3'h2) || (m == 3'h4);
    endfunction

    // symmetric saturation to +-lim
    function automatic logic signed [31:0] clamp(
        input logic signed [31:0] x, input logic signed [31:0] lim);
        if (x > lim) return lim;
        if (x < -lim) return -lim;
        return x;
    endfunction

    // fixed-point product, arithmetic shift, cut to 32 bits
    function automatic logic signed [31:0] mul_shift(
        input logic signed [31:0] a, input logic signed [16:0] b,
        input int sh);
        logic signed [48:0] p;
        p = a * b;
        p = p >>> sh;
        return p[31:0];
    endfunction
endpackage

// ### hdl/pidrs_timer.sv
// qualification timer: counts ms ticks while a level condition holds
`timescale 1ns/1ps
`default_nettype none
module pidrs_timer (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // condition and control
    input wire logic i_tick,
    input wire logic i_cond,
    input wire logic i_clr,
    input wire logic [15:0] i_limit,
    // result
    output logic o_done
);
    logic [15:0] cnt_r, cnt_nxt;
    logic done_r, done_nxt;

    // count restarts whenever the condition drops or a clear arrives
    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        if (i_clr || !i_cond) begin
            cnt_nxt = 16'h0000;
        end else if (cnt_r >= i_limit) begin
            done_nxt = 1'b1;
        end else if (i_tick) begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cnt_r <= 16'h0000;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign o_done = done_r;

    chk_timer_restart: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst) !i_cond |=> cnt_r == 16'h0000 && !done_r)
        else $error("timer did not restart when condition dropped");
endmodule
`default_nettype wire

// ### hdl/pidrs_ramp.sv
// target soft starter: slews the target by one lsb per step interval
`timescale 1ns/1ps
`default_nettype none
module pidrs_ramp #(
    parameter int P_UNIT_CYC = pidrs_pkg::RAMP_UNIT_CYC
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // control
    input wire logic i_enable,
    input wire logic [15:0] i_ramp_time,
    input wire logic signed [15:0] i_target,
    // ramped value
    output logic signed [15:0] o_value
);
    logic signed [15:0] val_r, val_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [31:0] interval;

    // one lsb per ramp_time * unit, so full scale takes ramp_time * 0.1 s
    always_comb begin
        interval = 32'(i_ramp_time) * 32'(P_UNIT_CYC);
        val_nxt = val_r;
        cnt_nxt = cnt_r + 32'h1;
        if (!i_enable || i_ramp_time == 16'h0000) begin
            val_nxt = i_target;
            cnt_nxt = 32'h0;
        end else if (cnt_r + 32'h1 >= interval) begin
            cnt_nxt = 32'h0;
            if (val_r < i_target) val_nxt = val_r + 16'sh0001;
            else if (val_r > i_target) val_nxt = val_r - 16'sh0001;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            val_r <= 16'sh0000;
            cnt_r <= 32'h0;
        end else begin
            val_r <= val_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign o_value = val_r;

    chk_ramp_slew: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst)
        i_enable && $past(i_enable) && i_ramp_time != 16'h0000
        |-> (val_r - $past(val_r) <= 16'sh0001)
            && ($past(val_r) - val_r <= 16'sh0001))
        else $error("soft starter moved more than one step");
endmodule
`default_nettype wire

// ### hdl/pidrs_top.sv
// pid regulator with output shaping, feedback-loss and sleep supervision
//
// Behaviour
// - integral term is clamped to the integral limit setting
// - regulator output is clamped to the output limit, 100 % = max freq
// - offset in 0.1 % steps is added to the regulator result
// - output passes a first-order low-pass with settable time constant
// - polarity select negates the output
// - output is multiplied by the output gain
// - negative output per selection; reverse prohibit forces it to zero
// - soft starter ramps the target with the ramp time setting
// - loss mode 1: feedback low past loss time raises an alarm only
// - loss mode 2: same condition faults, coasts and drives fault contact
// - output below sleep level for sleep time stops the drive
// - output above sleep level for sleep time resumes operation
// - sleep is disabled while the regulator is disabled
// - contact code 19 disables regulator; target becomes frequency ref
// - contact code 30 clears the integral while on
// - contact code 31 holds the integral while on
// - contact code 34 enables the soft starter while on
// - soft starter acts only when the reference is the target
// - contact code 35 inverts the input characteristic while on
// - derivative time zero removes the derivative term
// - methods 1/2 output frequency, 3/4 compensate; 1/3 d on error
`timescale 1ns/1ps
`default_nettype none
module pidrs_top #(
    parameter int P_TICK_CYC = pidrs_pkg::TICK_CYC,
    parameter int P_N_TERM = 5
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // process values, 0.01 % per lsb
    input wire logic signed [15:0] i_target,
    input wire logic signed [15:0] i_feedback,
    input wire logic signed [15:0] i_freq_ref,
    input wire logic i_target_from_ref,
    // contact terminals and their function codes
    input wire logic [P_N_TERM-1:0] i_contact,
    input wire logic [P_N_TERM*8-1:0] i_contact_input_function,
    // run and fault reset commands
    input wire logic i_run_cmd,
    input wire logic i_fault_reset,
    // regulator settings
    input wire logic [2:0] i_regulator_method_select,
    input wire logic [15:0] i_prop_gain,
    input wire logic [15:0] i_integral_gain,
    input wire logic [15:0] i_deriv_time,
    input wire logic [15:0] i_integral_limit,
    input wire logic [15:0] i_output_limit,
    input wire logic signed [15:0] i_output_offset,
    input wire logic [3:0] i_output_filter_time,
    input wire logic i_output_polarity_select,
    input wire logic [15:0] i_output_gain,
    input wire logic i_negative_output_select,
    input wire logic i_reverse_prohibit,
    input wire logic [15:0] i_target_ramp_time,
    // supervision settings, times in ms
    input wire logic [1:0] i_feedback_loss_mode,
    input wire logic signed [15:0] i_feedback_loss_level,
    input wire logic [15:0] i_feedback_loss_time,
    input wire logic signed [15:0] i_sleep_level,
    input wire logic [15:0] i_sleep_time,
    // results
    output logic signed [15:0] o_freq_ref,
    output logic signed [15:0] o_pid_output,
    // status
    output logic o_run_enable,
    output logic o_coast_stop,
    output logic o_loss_alarm,
    output logic o_fault_contact,
    output logic o_sleeping,
    output logic o_pid_active
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    // ---- control period tick
    logic [31:0] tcnt_r, tcnt_nxt;
    logic tick_r, tick_nxt;

    // period counter; regulator arithmetic advances on the tick only, except the integral clear, which acts at once
    always_comb begin
        tick_nxt = 1'b0;
        tcnt_nxt = tcnt_r + 32'h1;
        if (tcnt_r >= 32'(P_TICK_CYC - 1)) begin
            tcnt_nxt = 32'h0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            tcnt_r <= 32'h0;
            tick_r <= 1'b0;
        end else begin
            tcnt_r <= tcnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    // ---- contact input decode: any terminal with the code and on
    logic [P_N_TERM-1:0] f_dis, f_irst, f_ihold, f_soft, f_inv;
    logic c_dis, c_irst, c_ihold, c_soft, c_inv;

    genvar gt;
    generate
        for (gt = 0; gt < P_N_TERM; gt++) begin : g_term
            logic [7:0] code;
            assign code = i_contact_input_function[gt*8 +: 8];
            assign f_dis[gt] = i_contact[gt]
                && code == pidrs_pkg::CODE_DISABLE;
            assign f_irst[gt] = i_contact[gt]
                && code == pidrs_pkg::CODE_INT_RESET;
            assign f_ihold[gt] = i_contact[gt]
                && code == pidrs_pkg::CODE_INT_HOLD;
            assign f_soft[gt] = i_contact[gt]
                && code == pidrs_pkg::CODE_SOFT_START;
            assign f_inv[gt] = i_contact[gt]
                && code == pidrs_pkg::CODE_INPUT_INV;
        end
    endgenerate

    assign c_dis = |f_dis;
    assign c_irst = |f_irst;
    assign c_ihold = |f_ihold;
    assign c_soft = |f_soft;
    assign c_inv = |f_inv;

    // ---- target soft starter, only on the reference path
    logic signed [15:0] tgt_eff;
    logic ramp_en;

    assign ramp_en = c_soft && i_target_from_ref;

    pidrs_ramp u_ramp (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_enable(ramp_en),
        .i_ramp_time(i_target_ramp_time),
        .i_target(i_target),
        .o_value(tgt_eff)
    );

    // ---- regulator datapath
    logic signed [31:0] integ_r, integ_nxt;
    logic signed [31:0] dprev_r, dprev_nxt;
    logic signed [31:0] filt_r, filt_nxt;
    logic signed [15:0] out_r, out_nxt;
    logic signed [15:0] freq_r, freq_nxt;
    logic signed [31:0] tg, fb, err, p_term, d_src, d_term, i_sum;
    logic signed [31:0] ilim, olim, sum, offs, pol, gained, pid, base;
    logic method_ok, pid_off;

    assign method_ok = i_regulator_method_select >= pidrs_pkg::METHOD_FIRST
        && i_regulator_method_select <= pidrs_pkg::METHOD_LAST;
    // an unknown method is treated as regulator off rather than guessed
    assign pid_off = c_dis || !method_ok;

    // one pass through P, I, D, limit, offset, filter, sign, gain
    always_comb begin
        tg = 32'(tgt_eff);
        fb = 32'(i_feedback);
        err = c_inv ? fb - tg : tg - fb;
        ilim = 32'({1'b0, i_integral_limit});
        olim = 32'({1'b0, i_output_limit});
        if (olim > pidrs_pkg::FULL_SCALE) olim = pidrs_pkg::FULL_SCALE;
        p_term = pidrs_pkg::mul_shift(err, 17'({1'b0, i_prop_gain}),
            pidrs_pkg::KP_FRAC);
        i_sum = integ_r + pidrs_pkg::mul_shift(err,
            17'({1'b0, i_integral_gain}), pidrs_pkg::KI_FRAC);
        integ_nxt = integ_r;
        if (c_irst) begin
            integ_nxt = pidrs_pkg::ACC_RST;
        end else if (tick_r && !c_ihold) begin
            integ_nxt = pidrs_pkg::clamp(i_sum, ilim);
        end
        // derivative source per method
        d_src = pidrs_pkg::diff_fb(i_regulator_method_select) ? -fb
            : err;
        d_term = 32'sh0;
        if (i_deriv_time != 16'h0000) begin
            d_term = pidrs_pkg::mul_shift(d_src - dprev_r,
                17'({1'b0, i_deriv_time}), pidrs_pkg::KD_FRAC);
        end
        dprev_nxt = tick_r ? d_src : dprev_r;
        sum = pidrs_pkg::clamp(p_term + integ_nxt + d_term, olim);
        offs = sum + pidrs_pkg::mul_shift(32'(i_output_offset),
            pidrs_pkg::OFFSET_SCALE, 0);
        // shift filter: time constant is 2^n periods, cheap and monotone
        filt_nxt = filt_r;
        if (tick_r) begin
            filt_nxt = filt_r + ((offs - filt_r) >>> i_output_filter_time);
        end
        pol = i_output_polarity_select ? -filt_nxt : filt_nxt;
        gained = pidrs_pkg::mul_shift(pol, 17'({1'b0, i_output_gain}),
            pidrs_pkg::GAIN_FRAC);
        pid = pidrs_pkg::clamp(gained, pidrs_pkg::VAL_MAX);
        if (pid < 32'sh0 && (i_reverse_prohibit
            || !i_negative_output_select)) begin
            pid = 32'sh0;
        end
        // frequency reference per method, or target when disabled
        if (pid_off) begin
            base = tg;
        end else if (pidrs_pkg::is_comp(i_regulator_method_select)) begin
            base = 32'(i_freq_ref) + pid;
        end else begin
            base = pid;
        end
        base = pidrs_pkg::clamp(base, pidrs_pkg::VAL_MAX);
        out_nxt = tick_r ? pid[15:0] : out_r;
        freq_nxt = tick_r ? base[15:0] : freq_r;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            integ_r <= pidrs_pkg::ACC_RST;
            dprev_r <= pidrs_pkg::ACC_RST;
            filt_r <= pidrs_pkg::ACC_RST;
            out_r <= pidrs_pkg::OUT_RST;
            freq_r <= pidrs_pkg::OUT_RST;
        end else begin
            integ_r <= integ_nxt;
            dprev_r <= dprev_nxt;
            filt_r <= filt_nxt;
            out_r <= out_nxt;
            freq_r <= freq_nxt;
        end
    end

    // ---- supervision timers
    logic loss_cond, loss_done, sleep_cond, sleep_done, st_change;
    pidrs_pkg::pidrs_state_e state_r, state_nxt;

    assign loss_cond = i_feedback_loss_mode != 2'h0
        && i_feedback < i_feedback_loss_level;
    // sleeping watches for the rise, running watches for the fall
    assign sleep_cond = !pid_off && (state_r == pidrs_pkg::ST_SLEEP
        ? out_r > i_sleep_level : out_r < i_sleep_level);
    assign st_change = state_nxt != state_r;

    pidrs_timer u_loss_tmr (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_tick(tick_r),
        .i_cond(loss_cond),
        .i_clr(1'b0),
        .i_limit(i_feedback_loss_time),
        .o_done(loss_done)
    );

    // clearing on every state change keeps a stale done from bouncing back
    pidrs_timer u_sleep_tmr (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_tick(tick_r),
        .i_cond(sleep_cond),
        .i_clr(st_change),
        .i_limit(i_sleep_time),
        .o_done(sleep_done)
    );

    // ---- supervision state and status flags
    logic alarm_r, alarm_nxt;
    logic run_r, run_nxt;
    logic coast_r, coast_nxt;

    // fault outranks sleep; a fault holds until reset with feedback back
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pidrs_pkg::ST_RUN: begin
                if (loss_done && i_feedback_loss_mode
                    == pidrs_pkg::LOSS_FAULT) begin
                    state_nxt = pidrs_pkg::ST_FAULT;
                end else if (sleep_done && !pid_off) begin
                    state_nxt = pidrs_pkg::ST_SLEEP;
                end
            end
            pidrs_pkg::ST_SLEEP: begin
                if (loss_done && i_feedback_loss_mode
                    == pidrs_pkg::LOSS_FAULT) begin
                    state_nxt = pidrs_pkg::ST_FAULT;
                end else if (pid_off || sleep_done) begin
                    state_nxt = pidrs_pkg::ST_RUN;
                end
            end
            pidrs_pkg::ST_FAULT: begin
                if (i_fault_reset && !loss_cond && !loss_done) begin
                    state_nxt = pidrs_pkg::ST_RUN;
                end
            end
            default: state_nxt = pidrs_pkg::ST_RUN;
        endcase
        alarm_nxt = loss_done
            && i_feedback_loss_mode == pidrs_pkg::LOSS_ALARM;
        run_nxt = i_run_cmd && state_nxt == pidrs_pkg::ST_RUN;
        coast_nxt = state_nxt == pidrs_pkg::ST_FAULT;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_r <= pidrs_pkg::ST_RUN;
            alarm_r <= 1'b0;
            run_r <= 1'b0;
            coast_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            alarm_r <= alarm_nxt;
            run_r <= run_nxt;
            coast_r <= coast_nxt;
        end
    end

    // outputs from flip-flops, except o_pid_active, which follows the contacts and method directly
    assign o_freq_ref = freq_r;
    assign o_pid_output = out_r;
    assign o_run_enable = run_r;
    assign o_coast_stop = coast_r;
    assign o_fault_contact = coast_r;
    assign o_loss_alarm = alarm_r;
    assign o_sleeping = state_r == pidrs_pkg::ST_SLEEP;
    assign o_pid_active = !pid_off;

    // ---- checks
    sequence s_sleep_due;
        state_r == pidrs_pkg::ST_RUN && sleep_done && !pid_off
            && !loss_done;
    endsequence

    sequence s_wake_due;
        state_r == pidrs_pkg::ST_SLEEP && sleep_done && !pid_off
            && !loss_done;
    endsequence

    chk_integ_bound: assert property (tick_r && !c_irst
        |=> integ_r <= $past(ilim) && integ_r >= -$past(ilim))
        else $error("integral left its limit");

    chk_integ_clear: assert property (c_irst |=> integ_r == 32'sh0)
        else $error("integral not cleared by reset contact");

    chk_integ_hold: assert property (c_ihold && !c_irst
        |=> integ_r == $past(integ_r))
        else $error("integral moved while held");

    chk_no_reverse: assert property (tick_r && i_reverse_prohibit
        |=> out_r >= 16'sh0000)
        else $error("negative output with reverse prohibited");

    chk_disable_pass: assert property (tick_r && pid_off
        |=> freq_r == $past(tgt_eff))
        else $error("disabled regulator did not pass the target");

    chk_alarm_only: assert property (alarm_r
        |-> $past(i_feedback_loss_mode) == pidrs_pkg::LOSS_ALARM
            && $past(loss_done))
        else $error("alarm raised outside alarm mode");

    chk_fault_stop: assert property (loss_done
        && i_feedback_loss_mode == pidrs_pkg::LOSS_FAULT
        |=> state_r == pidrs_pkg::ST_FAULT ##0 o_fault_contact
            && !o_run_enable)
        else $error("loss fault did not stop the drive");

    chk_sleep_entry: assert property (s_sleep_due
        |=> o_sleeping ##0 !o_run_enable)
        else $error("sleep not entered after sleep time");

    chk_sleep_wake: assert property (s_wake_due |=> !o_sleeping)
        else $error("drive did not wake after sleep time");

    chk_sleep_off: assert property (pid_off && o_sleeping
        && !loss_done |=> !o_sleeping)
        else $error("sleep kept while regulator disabled");
endmodule
`default_nettype wire

// ### tb/pidrs_top_test.sv
// self-checking bench for the pid regulator supervisor
`timescale 1ns/1ps
`default_nettype none
module pidrs_top_test;
    localparam int TK = 20;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic signed [15:0] i_target = 16'sh0, i_feedback = 16'sh0;
    logic signed [15:0] i_freq_ref = 16'sh0, i_output_offset = 16'sh0;
    logic signed [15:0] i_feedback_loss_level = 16'sh0064;
    logic signed [15:0] i_sleep_level = 16'sh8000;
    logic [4:0] i_contact = 5'h00;
    logic [39:0] i_contact_input_function = {pidrs_pkg::CODE_INPUT_INV,
        pidrs_pkg::CODE_SOFT_START, pidrs_pkg::CODE_INT_HOLD,
        pidrs_pkg::CODE_INT_RESET, pidrs_pkg::CODE_DISABLE};
    logic [2:0] i_regulator_method_select = 3'h1;
    logic [15:0] i_prop_gain = 16'h0100, i_integral_gain = 16'h0000;
    logic [15:0] i_deriv_time = 16'h0000, i_integral_limit = 16'h2710;
    logic [15:0] i_output_limit = 16'h2710, i_output_gain = 16'h0100;
    logic [15:0] i_target_ramp_time = 16'h0001;
    logic [15:0] i_feedback_loss_time = 16'h0004, i_sleep_time = 16'h0002;
    logic [3:0] i_output_filter_time = 4'h0;
    logic [1:0] i_feedback_loss_mode = 2'h0;
    logic i_target_from_ref = 1'b1, i_run_cmd = 1'b1, i_fault_reset = 1'b0;
    logic i_output_polarity_select = 1'b0, i_negative_output_select = 1'b1;
    logic i_reverse_prohibit = 1'b0;
    logic signed [15:0] o_freq_ref, o_pid_output;
    logic o_run_enable, o_coast_stop, o_loss_alarm, o_fault_contact;
    logic o_sleeping, o_pid_active;
    int n_mismatch = 0;
    int check_count = 0;

    // short control period keeps the run brief; the tick and status waits scale with it
    pidrs_top #(.P_TICK_CYC(TK), .P_N_TERM(5)) i_pidrs_top (
        .i_core_clk, .i_sys_rst, .i_target, .i_feedback, .i_freq_ref,
        .i_target_from_ref, .i_contact, .i_contact_input_function,
        .i_run_cmd, .i_fault_reset, .i_regulator_method_select,
        .i_prop_gain, .i_integral_gain, .i_deriv_time, .i_integral_limit,
        .i_output_limit, .i_output_offset, .i_output_filter_time,
        .i_output_polarity_select, .i_output_gain, .i_negative_output_select,
        .i_reverse_prohibit, .i_target_ramp_time, .i_feedback_loss_mode,
        .i_feedback_loss_level, .i_feedback_loss_time, .i_sleep_level,
        .i_sleep_time, .o_freq_ref, .o_pid_output, .o_run_enable,
        .o_coast_stop, .o_loss_alarm, .o_fault_contact, .o_sleeping,
        .o_pid_active);

    // free-running 100 mhz clock
    always #5 i_core_clk = ~i_core_clk;

    // one comparison, counted, reported at once on mismatch
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // let n control periods pass plus the output register stage
    task automatic ticks(input int n);
        repeat (n * TK + 3) @(posedge i_core_clk);
        #1;
    endtask

    // bounded wait on a status output; a timeout ends the run
    task automatic wait_for(input int sel, input logic lvl);
        int k;
        logic v;
        for (k = 0; k < 12 * TK; k++) begin
            @(posedge i_core_clk);
            #1;
            v = (sel == 0) ? o_loss_alarm : (sel == 1) ? o_coast_stop
                : o_sleeping;
            if (v === lvl)
                return;
        end
        n_mismatch++;
        $display("unexpected at %0t: status wait ran out", $time);
        conclude();
    endtask

    // output shaping chain with proportional action only
    task automatic s_shaping;
        @(posedge i_core_clk);
        i_target <= 16'sh1388;
        i_output_limit <= 16'h07d0;
        ticks(3);
        chk(o_pid_output, 16'h07d0);
        chk(o_freq_ref, 16'h07d0);
        @(posedge i_core_clk);
        i_regulator_method_select <= 3'h3;
        i_freq_ref <= 16'sh03e8;
        ticks(3);
        chk(o_freq_ref, 16'h0bb8);
        @(posedge i_core_clk);
        i_regulator_method_select <= 3'h1;
        i_output_limit <= 16'h2710;
        i_target <= 16'sh03e8;
        i_output_gain <= 16'h0200;
        ticks(3);
        chk(o_pid_output, 16'h07d0);
        @(posedge i_core_clk);
        i_output_polarity_select <= 1'b1;
        ticks(3);
        chk(o_pid_output, 16'hf830);
        @(posedge i_core_clk);
        i_negative_output_select <= 1'b0;
        ticks(3);
        chk(o_pid_output, 16'h0000);
        @(posedge i_core_clk);
        i_negative_output_select <= 1'b1;
        i_reverse_prohibit <= 1'b1;
        ticks(3);
        chk(o_pid_output, 16'h0000);
        @(posedge i_core_clk);
        i_reverse_prohibit <= 1'b0;
        i_output_polarity_select <= 1'b0;
        i_output_gain <= 16'h0100;
        i_output_offset <= 16'sh000a;
        ticks(3);
        chk(o_pid_output, 16'h044c);
        @(posedge i_core_clk);
        i_output_offset <= 16'sh0;
        i_contact <= 5'h10;
        ticks(3);
        chk(o_pid_output, 16'hfc18);
        @(posedge i_core_clk);
        i_contact <= 5'h00;
        i_output_filter_time <= 4'hf;
        ticks(3);
        chk(o_pid_output, 16'hfc18);
    endtask

    // integral only: clamp, hold and clear through contacts
    task automatic s_integral;
        @(posedge i_core_clk);
        i_output_filter_time <= 4'h0;
        i_prop_gain <= 16'h0000;
        i_integral_gain <= 16'h1000;
        i_integral_limit <= 16'h012c;
        ticks(6);
        chk(o_pid_output, 16'h012c);
        @(posedge i_core_clk);
        i_contact <= 5'h04;
        i_feedback <= 16'sh07d0;
        ticks(3);
        chk(o_pid_output, 16'h012c);
        @(posedge i_core_clk);
        i_contact <= 5'h02;
        ticks(2);
        chk(o_pid_output, 16'h0000);
    endtask

    // disable contact and an invalid method both switch regulation off
    task automatic s_disable;
        @(posedge i_core_clk);
        i_contact <= 5'h01;
        i_target <= 16'sh04d2;
        ticks(2);
        chk(o_freq_ref, 16'h04d2);
        chk({15'h0, o_pid_active}, 16'h0000);
        @(posedge i_core_clk);
        i_contact <= 5'h09;
        i_target <= 16'sh0;
        ticks(2);
        chk(o_freq_ref, 16'h04d2);
        @(posedge i_core_clk);
        i_contact <= 5'h08;
        i_target_from_ref <= 1'b0;
        i_regulator_method_select <= 3'h0;
        ticks(1);
        chk({15'h0, o_pid_active}, 16'h0000);
        chk(o_freq_ref, 16'h0000);
        @(posedge i_core_clk);
        i_regulator_method_select <= 3'h1;
        i_integral_gain <= 16'h0000;
        i_target <= 16'sh0;
    endtask

    // loss supervision: restart of the timer, alarm, then fault and reset
    task automatic s_loss;
        @(posedge i_core_clk);
        i_feedback <= 16'sh0;
        i_feedback_loss_mode <= pidrs_pkg::LOSS_ALARM;
        ticks(2);
        @(posedge i_core_clk);
        i_feedback <= 16'sh00c8;
        ticks(1);
        @(posedge i_core_clk);
        i_feedback <= 16'sh0;
        ticks(2);
        chk({15'h0, o_loss_alarm}, 16'h0000);
        wait_for(0, 1'b1);
        chk({15'h0, o_run_enable}, 16'h0001);
        @(posedge i_core_clk);
        i_feedback <= 16'sh00c8;
        wait_for(0, 1'b0);
        @(posedge i_core_clk);
        i_feedback_loss_mode <= pidrs_pkg::LOSS_FAULT;
        i_feedback <= 16'sh0;
        wait_for(1, 1'b1);
        #1;
        chk({14'h0, o_fault_contact, o_run_enable}, 16'h0002);
        @(posedge i_core_clk);
        i_feedback <= 16'sh00c8;
        i_fault_reset <= 1'b1;
        wait_for(1, 1'b0);
        @(posedge i_core_clk);
        i_fault_reset <= 1'b0;
        i_feedback_loss_mode <= 2'h0;
        i_feedback <= 16'sh0;
    endtask

    // sleep on low output, wake on high output, cancel by disable
    task automatic s_sleep;
        @(posedge i_core_clk);
        i_prop_gain <= 16'h0100;
        i_sleep_level <= 16'sh01f4;
        wait_for(2, 1'b1);
        #1;
        chk({15'h0, o_run_enable}, 16'h0000);
        @(posedge i_core_clk);
        i_target <= 16'sh07d0;
        wait_for(2, 1'b0);
        #1;
        chk({15'h0, o_run_enable}, 16'h0001);
        @(posedge i_core_clk);
        i_target <= 16'sh0;
        wait_for(2, 1'b1);
        @(posedge i_core_clk);
        i_contact <= 5'h01;
        repeat (3) @(posedge i_core_clk);
        #1;
        chk({15'h0, o_sleeping}, 16'h0000);
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        s_shaping();
        s_integral();
        s_disable();
        s_loss();
        s_sleep();
        conclude();
    end
endmodule
`default_nettype wire
